// ==== verilog/twi_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Core clock at 125 MHz, one phase per clock, four phases per cycle
// Notes: Definitions only
`ifndef TWI_REGS_SVH
`define TWI_REGS_SVH

// ==========================================================
// Timing configuration register
`define TWI_CFG_W 7
`define TWI_CFG_RESET 7'h3F
`define TWI_CFG_RATIO_LSB 0
`define TWI_CFG_ASSIGN_BIT 3
`define TWI_CFG_CNT_EDGE_BIT 4
`define TWI_CFG_SRC_BIT 5
`define TWI_CFG_EXT_EDGE_BIT 6

// ==========================================================
// Interrupt flag and enable bit positions
`define TWI_IRQ_TIMER_BIT 0
`define TWI_IRQ_PORT_BIT 1
`define TWI_IRQ_EXT_BIT 2
`define TWI_IRQ_GIE_BIT 7
`define TWI_VEC_W 11
`define TWI_VEC_IRQ 11'h008
`define TWI_VEC_SWI 11'h002

// ==========================================================
// Timing
`define TWI_CLK_PERIOD_NS 8
`define TWI_WDT_TIMEOUT_NS 18000000
`define TWI_WDT_BASE_CYCLES (`TWI_WDT_TIMEOUT_NS / `TWI_CLK_PERIOD_NS)
`define TWI_WR_INHIBIT 2'h2
`define TWI_PHASE_T2 2'h1
`define TWI_PHASE_T4 2'h3
`define TWI_PS_RESET 8'hFF
`define TWI_PS_CLEAR 8'h00

`endif

// ==== verilog/twi_pkg.sv ====
// Purpose: Types shared by the timer, watchdog and prescaler logic
// Assumes: Nothing beyond the constants header
// Notes: Field order matches the configuration register bit order
package twi_pkg;
  // ==========================================================
  // Configuration register layout, bit 6 down to bit 0
  typedef struct packed {
    logic extIrqEdgeSel;
    logic countSourceSel;
    logic countEdgeSel;
    logic prescaleAssign;
    logic [2:0] prescaleRatio;
  } twi_cfg_t;

  // Which unit owns the shared prescaler
  typedef enum logic {TWI_OWN_TIMER, TWI_OWN_WDT} twi_owner_t;
endpackage

// ==== verilog/twi_ps_if.sv ====
// Purpose: Link between the control logic and the shared prescaler
// Assumes: One clock
// Notes: The owner modport is the prescaler itself
`timescale 1ns/1ns
`default_nettype none
interface twi_ps_if;
  logic step;
  logic clear;
  logic [3:0] bits;
  logic tick;
  logic [7:0] count;
  modport owner (input step, input clear, input bits, output tick, output count);
  modport user (output step, output clear, output bits, input tick, input count);
endinterface
`default_nettype wire

// ==== verilog/twi_prescaler.sv ====
// Purpose: Shared 8-bit down-counting prescaler
// Assumes: Step and clear are one-cycle pulses
// Notes: Tick marks every 2^bits steps; bits of zero passes every step
`timescale 1ns/1ns
`default_nettype none
`include "twi_regs.svh"
module twi_prescaler
  import twi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  twi_ps_if.owner ps
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [8:0] maskWide;
  logic [7:0] mask;

  // ==========================================================
  // Ratio mask and tick
  assign count_next = count_reg - 8'h01;
  assign maskWide = (9'h001 << ps.bits) - 9'h001;
  assign mask = maskWide[7:0];
  assign ps.tick = ps.step && !ps.clear && ((count_next & mask) == 8'h00);
  assign ps.count = count_reg;

  // Counter; not visible to software, reset to all ones
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_reg <= `TWI_PS_RESET;
    end else if (ps.clear) begin
      count_reg <= `TWI_PS_CLEAR;
    end else if (ps.step) begin
      count_reg <= count_next;
    end
  end

  ps_reset_a: assert property (@(posedge core_clk) !rstn |=> count_reg == 8'hFF)
    else $error("prescaler not all ones after reset");
endmodule
`default_nettype wire

// ==== verilog/twi_timer_irq.sv ====
// Purpose: Timer0, watchdog, shared prescaler and three-source interrupt logic
// Assumes: Core strobes are one-cycle pulses; one core clock per phase
// Notes: Watchdog oscillator modelled on the core clock, which keeps running
`timescale 1ns/1ns
`default_nettype none
`include "twi_regs.svh"
// Functional notes
// - Configuration-load instruction copies accumulator into 7-bit write-only register.
// - Reset sets all configuration bits except external edge select, which clears.
// - Ratio code gives timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// - Assign bit one gives prescaler to watchdog, zero to timer.
// - Count edge select one counts falling pin edges, zero rising.
// - Source select one picks the external pin, zero the instruction clock.
// - Timer mode increments each cycle; a write suppresses two increments.
// - External edge select one triggers on rising, zero on falling.
// - Counter mode samples prescaler output at phases two and four.
// - Watchdog time-out resets the device and clears the time-out status.
// - Watchdog disabled while its enable bit is zero.
// - Watchdog time-out nominally 18 ms, times the ratio when assigned.
// - Watchdog clear resets watchdog count and prescaler if assigned.
// - Sleep resets watchdog count and prescaler if assigned.
// - Prescaler is one 8-bit down counter serving one unit.
// - Timer writes clear the prescaler while assigned to the timer.
// - Prescaler is hidden from software and resets to all ones.
// - Three sources, each enabled, all gated by global enable bit.
// - Taken interrupt clears global enable and vectors to 008h.
// - Return instruction sets the global enable again.
// - Flags set regardless of enable except port flag; reads return flags AND enables.
// - Software interrupt instruction vectors to 002h.
// - Timer wrap FFh to 00h sets timer overflow flag, bit 0.
// - Selected edge on external pin sets external flag, bit 2.
// - Enabled port B change sets port change flag, bit 1.
module twi_timer_irq
  import twi_pkg::*;
#(
  parameter int WDT_BASE_CYCLES = `TWI_WDT_BASE_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cfgLoad,
  input wire logic [7:0] accumulator,
  input wire logic timerWrite,
  input wire logic [7:0] timerWrData,
  input wire logic watchdogClearInstr,
  input wire logic sleepInstr,
  input wire logic irqReturnInstr,
  input wire logic swIrqInstr,
  input wire logic flagWrite,
  input wire logic [7:0] flagWrData,
  input wire logic enableWrite,
  input wire logic [7:0] enableWrData,
  input wire logic watchdogEnableBit,
  input wire logic extCountPin,
  input wire logic extIrqPin,
  input wire logic portChangeEvent,
  output logic [7:0] timer0Count,
  output logic [7:0] irqFlagRead,
  output logic [7:0] irqEnableRead,
  output logic irqTake,
  output logic [`TWI_VEC_W-1:0] irqVector,
  output logic wdtResetReq,
  output logic timeoutStatusClr
);
  twi_cfg_t cfg_reg;
  twi_owner_t owner;
  logic [1:0] phase_reg;
  logic [1:0] inhibit_reg;
  logic countPin_reg;
  logic extPin_reg;
  logic pending_reg;
  logic [21:0] wdtCnt_reg;
  logic [2:0] flag_reg;
  logic [2:0] en_reg;
  logic gie_reg;
  logic cycleEnd;
  logic pinEdge;
  logic samplePhase;
  logic timerStep;
  logic timerInc;
  logic wdtEnabled;
  logic wdtBaseTick;
  logic wdtTimeout;
  logic wdtRestart;
  logic extEdge;
  logic [2:0] flagSet;
  logic takeNow;
  logic countRaw;

  twi_ps_if psBus ();

  twi_prescaler u_prescaler (
    .core_clk(core_clk),
    .rstn(rstn),
    .ps(psBus)
  );

  // ==========================================================
  // Configuration register, loaded only by its instruction
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg_reg <= `TWI_CFG_RESET;
    end else if (cfgLoad) begin
      cfg_reg <= accumulator[`TWI_CFG_W-1:0];
    end
  end

  assign owner = cfg_reg.prescaleAssign ? TWI_OWN_WDT : TWI_OWN_TIMER;

  // ==========================================================
  // Phase clock: four core clocks per instruction cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign cycleEnd = (phase_reg == `TWI_PHASE_T4);
  assign samplePhase = (phase_reg == `TWI_PHASE_T2) || (phase_reg == `TWI_PHASE_T4);

  // ==========================================================
  // Input edge detection; pins are already synchronous
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      countPin_reg <= 1'b0;
      extPin_reg <= 1'b0;
    end else begin
      countPin_reg <= extCountPin;
      extPin_reg <= extIrqPin;
    end
  end

  // Selected count edge, falling when the edge bit is set
  assign pinEdge = cfg_reg.countEdgeSel ? (countPin_reg && !extCountPin)
                                        : (!countPin_reg && extCountPin);
  assign extEdge = cfg_reg.extIrqEdgeSel ? (!extPin_reg && extIrqPin)
                                         : (extPin_reg && !extIrqPin);

  // ==========================================================
  // Source select; pin edges feed the prescaler directly while the timer owns it
  assign timerStep = cfg_reg.countSourceSel ? pinEdge : cycleEnd;

  // Prescaler hook-up; the unit without it sees every step
  assign psBus.step = (owner == TWI_OWN_TIMER) ? timerStep : wdtBaseTick;
  assign psBus.bits = (owner == TWI_OWN_TIMER) ? {1'b0, cfg_reg.prescaleRatio} + 4'h1
                                               : {1'b0, cfg_reg.prescaleRatio};
  assign psBus.clear = (owner == TWI_OWN_TIMER) ? timerWrite
                                                : wdtRestart;

  // Counter mode output is held until a phase two or four sample
  assign countRaw = (owner == TWI_OWN_TIMER) ? psBus.tick : timerStep;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pending_reg <= 1'b0;
    end else begin
      if (!cfg_reg.countSourceSel) begin
        pending_reg <= 1'b0;
      end else if (countRaw) begin
        pending_reg <= 1'b1; // set wins over the sample
      end else if (samplePhase) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // Timer mode steps at cycle end; counter mode only after sampling
  always_comb begin
    if (cfg_reg.countSourceSel) begin
      timerInc = pending_reg && samplePhase;
    end else if (owner == TWI_OWN_TIMER) begin
      timerInc = psBus.tick;
    end else begin
      timerInc = cycleEnd;
    end
  end

  // ==========================================================
  // Timer0 count with two-cycle inhibit after a write
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      timer0Count <= 8'h00;
      inhibit_reg <= 2'h0;
    end else if (timerWrite) begin
      timer0Count <= timerWrData;
      inhibit_reg <= `TWI_WR_INHIBIT;
    end else begin
      if (inhibit_reg != 2'h0 && cycleEnd) begin
        inhibit_reg <= inhibit_reg - 2'h1;
      end
      if (timerInc && inhibit_reg == 2'h0) begin
        timer0Count <= timer0Count + 8'h01;
      end
    end
  end

  // ==========================================================
  // Watchdog base period counter
  assign wdtEnabled = watchdogEnableBit;
  assign wdtRestart = watchdogClearInstr || sleepInstr;
  assign wdtBaseTick = wdtEnabled && !wdtRestart
                       && (wdtCnt_reg == 22'(WDT_BASE_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wdtCnt_reg <= 22'h000000;
    end else if (!wdtEnabled || wdtRestart || wdtBaseTick) begin
      wdtCnt_reg <= 22'h000000;
    end else begin
      wdtCnt_reg <= wdtCnt_reg + 22'h000001;
    end
  end

  // Time-out is the base tick, or the postscaled tick when assigned
  assign wdtTimeout = wdtEnabled
                      && ((owner == TWI_OWN_WDT) ? psBus.tick : wdtBaseTick);

  // Reset request and status clear, both registered pulses
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wdtResetReq <= 1'b0;
      timeoutStatusClr <= 1'b0;
    end else begin
      wdtResetReq <= wdtTimeout;
      timeoutStatusClr <= wdtTimeout;
    end
  end

  // ==========================================================
  // Interrupt flags; a hardware set beats a software clear
  assign flagSet[`TWI_IRQ_TIMER_BIT] = timerInc && inhibit_reg == 2'h0
                                       && !timerWrite && timer0Count == 8'hFF;
  assign flagSet[`TWI_IRQ_PORT_BIT] = portChangeEvent && en_reg[`TWI_IRQ_PORT_BIT];
  assign flagSet[`TWI_IRQ_EXT_BIT] = extEdge;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flag_reg <= 3'h0;
    end else if (flagWrite) begin
      flag_reg <= flagWrData[2:0] | flagSet;
    end else begin
      flag_reg <= flag_reg | flagSet;
    end
  end

  // Enables; hardware take beats return, which beats a software write
  assign takeNow = gie_reg && ((flag_reg & en_reg) != 3'h0);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      en_reg <= 3'h0;
    end else if (enableWrite) begin
      en_reg <= enableWrData[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gie_reg <= 1'b0;
    end else if (takeNow) begin
      gie_reg <= 1'b0;
    end else if (irqReturnInstr) begin
      gie_reg <= 1'b1;
    end else if (enableWrite) begin
      gie_reg <= enableWrData[`TWI_IRQ_GIE_BIT];
    end
  end

  // Vector fetch; a taken interrupt outranks the software one
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irqTake <= 1'b0;
      irqVector <= `TWI_VEC_W'(0);
    end else begin
      irqTake <= takeNow || swIrqInstr;
      if (takeNow) begin
        irqVector <= `TWI_VEC_IRQ;
      end else if (swIrqInstr) begin
        irqVector <= `TWI_VEC_SWI;
      end
    end
  end

  // Reads: flags masked by enables, unused bits zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irqFlagRead <= 8'h00;
      irqEnableRead <= 8'h00;
    end else begin
      irqFlagRead <= {5'h00, flag_reg & en_reg};
      irqEnableRead <= {gie_reg, 4'h0, en_reg};
    end
  end

  // ==========================================================
  // Checks
  cfg_reset_a: assert property (@(posedge core_clk) !rstn |=> cfg_reg == 7'h3F)
    else $error("configuration reset value wrong");
  cfg_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cfgLoad |=> cfg_reg == $past(accumulator[6:0]))
    else $error("configuration load lost");
  timer_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    timerWrite ##1 (!timerWrite)[*4] |-> timer0Count == $past(timerWrData, 4))
    else $error("timer stepped during write inhibit");
  ps_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (timerWrite && !cfg_reg.prescaleAssign) |=> psBus.count == 8'h00)
    else $error("timer write did not clear prescaler");
  wdt_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !watchdogEnableBit |=> !wdtResetReq)
    else $error("watchdog fired while disabled");
  wdt_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    watchdogClearInstr |=> wdtCnt_reg == 22'h000000 ##1 !wdtResetReq)
    else $error("watchdog clear ignored");
  irq_take_a: assert property (@(posedge core_clk) disable iff (!rstn)
    takeNow |=> irqTake && irqVector == 11'h008 && !gie_reg)
    else $error("interrupt not taken to 008h");
  irq_return_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (irqReturnInstr && !takeNow) |=> gie_reg)
    else $error("return did not set global enable");
  overflow_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
    flagSet[0] |=> flag_reg[0] && timer0Count == 8'h00)
    else $error("timer wrap flag missing");
  sw_irq_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (swIrqInstr && !takeNow) |=> irqTake && irqVector == 11'h002)
    else $error("software interrupt vector wrong");
endmodule
`default_nettype wire

// ==== sim/twi_core_model.sv ====
// Purpose: Processor core stand-in issuing timer, watchdog and interrupt strobes
// Assumes: Strobes are one-cycle pulses launched just after a rising edge
// Notes: Ops 0 cfg, 1 timer write, 2 wdt clear, 3 sleep, 4 return, 5 swi, 6 flags, 7 enables
`timescale 1ns/1ns
`default_nettype none
module twi_core_model
(
  input wire logic core_clk,
  output logic cfgLoad,
  output logic [7:0] accumulator,
  output logic timerWrite,
  output logic [7:0] timerWrData,
  output logic watchdogClearInstr,
  output logic sleepInstr,
  output logic irqReturnInstr,
  output logic swIrqInstr,
  output logic flagWrite,
  output logic [7:0] flagWrData,
  output logic enableWrite,
  output logic [7:0] enableWrData
);
  // ==========================================================
  // One strobe bit per instruction kind, one shared data bus
  logic [7:0] stb;
  logic [7:0] dat;

  // Idle bus from time zero
  initial begin
    stb <= 8'h00;
    dat <= 8'h00;
  end
  assign {enableWrite, flagWrite, swIrqInstr, irqReturnInstr} = stb[7:4];
  assign {sleepInstr, watchdogClearInstr, timerWrite, cfgLoad} = stb[3:0];
  assign accumulator = dat;
  assign timerWrData = dat;
  assign flagWrData = dat;
  assign enableWrData = dat;

  // ==========================================================
  // Hold for one edge, then release; data flips so stale values never look valid
  task automatic exec(input int op, input logic [7:0] d);
    @(posedge core_clk);
    stb <= 8'h01 << op;
    dat <= d;
    @(posedge core_clk);
    stb <= 8'h00;
    dat <= ~d;
  endtask

  // Clear after every load, so a changed owner cannot fire early
  task automatic setCfg(input logic [7:0] d);
    exec(0, d);
    exec(2, 8'h00);
  endtask
endmodule
`default_nettype wire

// ==== sim/twi_timer_irq_test.sv ====
// Purpose: Self-checking bench for the timer, watchdog and interrupt block
// Assumes: Watchdog base period shortened to 20 core clocks
// Notes: Pulse outputs are matched against notes queued by the stimulus
`timescale 1ns/1ns
`default_nettype none
module twi_timer_irq_test;
  localparam int WDT_CYC = 20;
  logic core_clk;
  logic rstn;
  logic watchdogEnableBit;
  logic extCountPin;
  logic extIrqPin;
  logic portChangeEvent;
  logic cfgLoad, timerWrite, watchdogClearInstr, sleepInstr;
  logic irqReturnInstr, swIrqInstr, flagWrite, enableWrite;
  logic [7:0] accumulator, timerWrData, flagWrData, enableWrData;
  logic [7:0] timer0Count, irqFlagRead, irqEnableRead, v;
  logic [10:0] irqVector;
  logic irqTake, wdtResetReq, timeoutStatusClr;
  logic [11:0] expQ[$];
  logic [2:0] codes[3] = '{3'h0, 3'h1, 3'h7};
  int miscompares = 0;
  int nCompared = 0;
  int n;

  // ==========================================================
  // Clock and instances
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  twi_core_model core (.core_clk(core_clk), .cfgLoad(cfgLoad), .accumulator(accumulator),
    .timerWrite(timerWrite), .timerWrData(timerWrData), .sleepInstr(sleepInstr),
    .watchdogClearInstr(watchdogClearInstr), .irqReturnInstr(irqReturnInstr),
    .swIrqInstr(swIrqInstr), .flagWrite(flagWrite), .flagWrData(flagWrData),
    .enableWrite(enableWrite), .enableWrData(enableWrData));

  twi_timer_irq #(.WDT_BASE_CYCLES(WDT_CYC)) dut (.core_clk(core_clk), .rstn(rstn),
    .cfgLoad(cfgLoad), .accumulator(accumulator), .timerWrite(timerWrite),
    .timerWrData(timerWrData), .watchdogClearInstr(watchdogClearInstr),
    .sleepInstr(sleepInstr), .irqReturnInstr(irqReturnInstr), .swIrqInstr(swIrqInstr),
    .flagWrite(flagWrite), .flagWrData(flagWrData), .enableWrite(enableWrite),
    .enableWrData(enableWrData), .watchdogEnableBit(watchdogEnableBit),
    .extCountPin(extCountPin), .extIrqPin(extIrqPin), .portChangeEvent(portChangeEvent),
    .timer0Count(timer0Count), .irqFlagRead(irqFlagRead), .irqEnableRead(irqEnableRead),
    .irqTake(irqTake), .irqVector(irqVector), .wdtResetReq(wdtResetReq),
    .timeoutStatusClr(timeoutStatusClr));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Sample just after the edge, when registered outputs have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // Cycles between two successive timer changes
  task automatic period(output int k);
    logic [7:0] s;
    #1; // Off the edge, so a pending update is not missed
    s = timer0Count;
    for (k = 0; k < 3000 && timer0Count === s; k++) cyc(1);
    s = timer0Count;
    for (k = 0; k < 3000 && timer0Count === s; k++) cyc(1);
  endtask

  task automatic waitWdt(output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (wdtResetReq !== 1'b1 && k < 500);
  endtask

  // ==========================================================
  // Each pulse output takes the oldest note; an unexpected pulse meets X
  always @(posedge core_clk) begin
    if (rstn === 1'b1 && (irqTake === 1'b1 || wdtResetReq === 1'b1)) begin
      chk((wdtResetReq === 1'b1) ? {timeoutStatusClr, 11'h7FF} : {1'b0, irqVector},
        (expQ.size() > 0) ? expQ.pop_front() : 12'hXXX);
    end
  end

  // Cut a hang short; the tests need well under this span
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h585129B7));
    rstn <= 1'b0;
    watchdogEnableBit <= 1'b0;
    extCountPin <= 1'b1;
    extIrqPin <= 1'b0;
    portChangeEvent <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(1);
    chk(irqFlagRead | irqEnableRead, 12'h000);
    // Counter mode: reset settings count falling edges, then load rising
    for (int e = 1; e >= 0; e--) begin
      if (e == 0) begin
        @(posedge core_clk) extCountPin <= 1'b0;
        core.setCfg(8'h28);
        #1;
      end
      v = timer0Count;
      @(posedge core_clk) extCountPin <= ~extCountPin;
      cyc(8);
      chk(timer0Count, v + 8'h01);
      @(posedge core_clk) extCountPin <= ~extCountPin;
      cyc(8);
      chk(timer0Count, v + 8'h01);
    end
    // Timer mode, bare, then with prescaler ratios
    core.setCfg(8'h08);
    period(n);
    chk(12'(n), 12'h004);
    foreach (codes[i]) begin
      core.setCfg({5'h00, codes[i]});
      period(n);
      chk(12'(n), 12'h008 << codes[i]);
    end
    // Write inhibit: two cycle ends skipped, the third counts
    core.setCfg(8'h08);
    v = 8'($urandom_range(200, 0));
    core.exec(1, v);
    cyc(7);
    chk(timer0Count, v);
    cyc(4);
    chk(timer0Count, v + 8'h01);
    // Overflow flag, masking, vectored take and return
    core.exec(1, 8'hFE);
    for (n = 0; n < 100 && timer0Count !== 8'h00; n++) cyc(1);
    cyc(1);
    chk(irqFlagRead, 8'h00);
    core.exec(7, 8'h01);
    cyc(1);
    chk(irqFlagRead, 8'h01);
    expQ.push_back(12'h008);
    core.exec(7, 8'h81);
    cyc(3);
    chk(irqEnableRead, 8'h01);
    core.exec(6, 8'h00);
    core.exec(4, 8'h00);
    cyc(1);
    chk(irqEnableRead, 8'h81);
    core.exec(7, 8'h00);
    expQ.push_back(12'h002);
    core.exec(5, 8'h00);
    cyc(3);
    // External pin: inactive edge ignored, selected edge flags
    for (int e = 0; e < 2; e++) begin
      @(posedge core_clk) extIrqPin <= e[0];
      core.setCfg(8'(8'h08 | (e << 6)));
      core.exec(6, 8'h00);
      core.exec(7, 8'h04);
      @(posedge core_clk) extIrqPin <= ~e[0];
      cyc(3);
      chk(irqFlagRead, 8'h00);
      @(posedge core_clk) extIrqPin <= e[0];
      cyc(3);
      chk(irqFlagRead, 8'h04);
    end
    // Port change only flags while its enable is set
    core.exec(7, 8'h00);
    for (int e = 0; e < 2; e++) begin
      @(posedge core_clk) portChangeEvent <= 1'b1;
      @(posedge core_clk) portChangeEvent <= 1'b0;
      core.exec(7, 8'h02);
      cyc(1);
      chk(irqFlagRead, 8'(e << 1));
    end
    // Watchdog: silent while disabled, then bare, prescaled, cleared, slept
    core.setCfg(8'h00);
    cyc(60);
    @(posedge core_clk) watchdogEnableBit <= 1'b1;
    repeat (4) expQ.push_back(12'hFFF);
    waitWdt(n);
    waitWdt(n);
    chk(12'(n >= 19 && n <= 21), 12'h001);
    core.setCfg(8'h09);
    waitWdt(n);
    waitWdt(n);
    chk(12'(n >= 38 && n <= 42), 12'h001);
    for (int op = 2; op < 4; op++) begin
      expQ.push_back(12'hFFF);
      cyc(25);
      core.exec(op, 8'h00);
      waitWdt(n);
      chk(12'(n >= 36 && n <= 42), 12'h001);
    end
    @(posedge core_clk) watchdogEnableBit <= 1'b0;
    cyc(100);
    chk(12'(expQ.size()), 12'h000);
    end_sim();
  end
endmodule
`default_nettype wire
